//--- hw/spc_pkg.sv
// Constants for the serial port pin control block
package spc_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [4:0] SPC_OFS_PIN_CTRL = 5'h00;
  localparam logic [4:0] SPC_OFS_GPIO = 5'h04;
  localparam logic [4:0] SPC_OFS_STATUS = 5'h08;
  localparam logic [4:0] SPC_OFS_TX_DATA = 5'h0C;
  localparam logic [4:0] SPC_OFS_RX_DATA = 5'h10;
  // ==========================================================
  // Pin control fields
  localparam int SPC_PC_RX_CLOCK_DIR = 0;
  localparam int SPC_PC_TX_CLOCK_DIR = 1;
  localparam int SPC_PC_RX_GPIO_EN = 2;
  localparam int SPC_PC_TX_GPIO_EN = 3;
  localparam int SPC_PC_FS_DIR = 4;
  localparam int SPC_PC_W = 5;
  localparam logic [4:0] SPC_PC_RESET = 5'h00;
  // ==========================================================
  // General purpose fields: values [2:0], drive enables [5:3]
  // Bit order in each group: rx clock, tx clock, tx data
  localparam int SPC_GP_RXC = 0;
  localparam int SPC_GP_TXC = 1;
  localparam int SPC_GP_TXD = 2;
  localparam int SPC_GP_DIR = 3;
  localparam int SPC_GP_W = 6;
  localparam logic [5:0] SPC_GP_RESET = 6'h00;
  // ==========================================================
  // Status fields
  localparam int SPC_ST_TX_CLOCK_PIN_LEVEL = 0;
  localparam int SPC_ST_RX_VALID = 1;
  localparam int SPC_ST_TX_BUSY = 2;
  localparam int SPC_ST_RXC_LEVEL = 3;
  localparam int SPC_ST_RXD_LEVEL = 4;
  // ==========================================================
  // Timing
  localparam int SPC_WORD_W = 8;
  localparam int SPC_CLK_HALF = 4;
endpackage

//--- hw/spc_pin_ctrl.sv
// Serial port pin control with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Receive clock pin clocks incoming serial bits
// R2: Receive gpio enable turns rx clock pin gpio
// R3: Receive clock direction bit drives the pin
// R4: Shift out on tx clock; dir 0 input
// R5: Transmit clock pin level readable in status
// R6: Transmit gpio enable turns tx pins gpio; frame sync pin goes input instead
// R7: Float input low tristates clock, data pins
// R8: Reset returns frame sync pin to input
module spc_pin_ctrl import spc_pkg::*; #(
  parameter int WORD_W = SPC_WORD_W,
  parameter int CLK_HALF = SPC_CLK_HALF
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_rx_link_clk,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_float_n,
  input wire logic i_serial_rx_clock_in,
  output logic o_serial_rx_clock_out,
  output logic o_serial_rx_clock_oe,
  input wire logic i_serial_tx_clock_in,
  output logic o_serial_tx_clock_out,
  output logic o_serial_tx_clock_oe,
  input wire logic i_serial_rx_data,
  output logic o_serial_tx_data_out,
  output logic o_serial_tx_data_oe,
  output logic o_tx_frame_sync_out,
  output logic o_tx_frame_sync_oe
);
  localparam int CW = $clog2(WORD_W + 1);
  localparam int DW = $clog2(CLK_HALF + 1);
  localparam logic [CW-1:0] CNT_W = CW'(WORD_W);
  localparam logic [DW-1:0] DIV_LAST = DW'(CLK_HALF - 1);

  // ==========================================================
  // Pin synchronisers
  logic fl_s1_r, fl_s2_r;
  logic txc_s1_r, txc_s2_r, txc_s3_r;
  logic rxc_s1_r, rxc_s2_r;
  logic rxd_s1_r, rxd_s2_r;
  always_ff @(posedge i_mclk) begin
    fl_s1_r <= i_float_n;
    fl_s2_r <= fl_s1_r;
    txc_s1_r <= i_serial_tx_clock_in;
    txc_s2_r <= txc_s1_r;
    txc_s3_r <= txc_s2_r;
    rxc_s1_r <= i_serial_rx_clock_in;
    rxc_s2_r <= rxc_s1_r;
    rxd_s1_r <= i_serial_rx_data;
    rxd_s2_r <= rxd_s1_r;
  end

  // ==========================================================
  // Avalon slave: one wait cycle, then the answer
  logic waitreq_r;
  logic [31:0] rdata_r;
  logic [SPC_PC_W-1:0] pc_r;
  logic [SPC_GP_W-1:0] gp_r;
  logic rx_valid_r;
  logic [WORD_W-1:0] rx_word_r;
  logic [CW-1:0] tx_cnt_r;
  wire req = i_read | i_write;
  wire take = req & ~waitreq_r;
  wire wr_take = take & i_write;
  wire sel_pc = i_address == SPC_OFS_PIN_CTRL;
  wire sel_gp = i_address == SPC_OFS_GPIO;
  wire sel_st = i_address == SPC_OFS_STATUS;
  wire sel_tx = i_address == SPC_OFS_TX_DATA;
  wire sel_rx = i_address == SPC_OFS_RX_DATA;
  wire rx_dir = pc_r[SPC_PC_RX_CLOCK_DIR];
  wire tx_dir = pc_r[SPC_PC_TX_CLOCK_DIR];
  wire rx_gpio = pc_r[SPC_PC_RX_GPIO_EN];
  wire tx_gpio = pc_r[SPC_PC_TX_GPIO_EN];
  wire tx_busy = tx_cnt_r != '0;
  wire [31:0] status_word = {27'h0000000, rxd_s2_r, rxc_s2_r,
    tx_busy, rx_valid_r, txc_s2_r}; // R5
  wire [31:0] rd_mux =
    sel_pc ? {{(32-SPC_PC_W){1'b0}}, pc_r} :
    sel_gp ? {{(32-SPC_GP_W){1'b0}}, gp_r} :
    sel_st ? status_word :
    sel_rx ? {{(32-WORD_W){1'b0}}, rx_word_r} : 32'h00000000;
  wire waitreq_nxt = ~(req & waitreq_r);
  wire [31:0] rdata_nxt = (i_read & waitreq_r) ? rd_mux : rdata_r;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      waitreq_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      waitreq_r <= waitreq_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign o_waitrequest = waitreq_r;
  assign o_readdata = rdata_r;

  // ==========================================================
  // Control registers
  wire [SPC_PC_W-1:0] pc_nxt =
    (wr_take & sel_pc) ? i_writedata[SPC_PC_W-1:0] : pc_r;
  wire [SPC_GP_W-1:0] gp_nxt =
    (wr_take & sel_gp) ? i_writedata[SPC_GP_W-1:0] : gp_r;
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      pc_r <= SPC_PC_RESET; // R8
      gp_r <= SPC_GP_RESET;
    end else begin
      pc_r <= pc_nxt;
      gp_r <= gp_nxt;
    end
  end

  // ==========================================================
  // Internal shift clock divider
  logic [DW-1:0] div_r;
  logic int_clk_r;
  wire div_wrap = div_r == DIV_LAST;
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      div_r <= '0;
      int_clk_r <= 1'b0;
    end else begin
      div_r <= div_wrap ? '0 : div_r + DW'(1);
      int_clk_r <= int_clk_r ^ div_wrap;
    end
  end

  // ==========================================================
  // Transmit shifter
  // The external clock is only seen after synchronising, so it
  // must run well below the system clock.
  logic [WORD_W-1:0] tx_sh_r;
  logic tx_bit_r;
  logic tx_prev_r;
  wire tx_lvl = tx_dir ? int_clk_r : txc_s3_r; // R4
  wire tx_rise = tx_lvl & ~tx_prev_r;
  wire tx_start = wr_take & sel_tx & ~tx_busy & ~tx_gpio;
  wire tx_step = tx_rise & tx_busy;
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      tx_sh_r <= '0;
      tx_cnt_r <= '0;
      tx_bit_r <= 1'b0;
      tx_prev_r <= 1'b1;
    end else begin
      tx_prev_r <= tx_lvl;
      if (tx_start) begin
        tx_sh_r <= i_writedata[WORD_W-1:0];
        tx_cnt_r <= CNT_W;
      end else if (tx_step) begin // R4
        tx_bit_r <= tx_sh_r[WORD_W-1];
        tx_sh_r <= {tx_sh_r[WORD_W-2:0], 1'b0};
        tx_cnt_r <= tx_cnt_r - CW'(1);
      end
    end
  end
  wire fs_nxt = tx_busy & (tx_cnt_r == CNT_W);

  // ==========================================================
  // Receive shifter on the link clock
  // The link clock stands still between frames, so clears reach
  // this side asynchronously; a clear released while the clock
  // runs may cost the first bit of a word.
  logic rx_rst_r, rx_clr_r;
  logic [WORD_W-1:0] rx_sh_l_r, rx_word_l_r;
  logic [CW-1:0] rx_cnt_l_r;
  logic rx_tog_l_r;
  wire rx_last_l = rx_cnt_l_r == CW'(WORD_W - 1);
  always_ff @(posedge i_mclk) begin
    rx_rst_r <= ~i_reset_n;
    rx_clr_r <= ~i_reset_n | rx_gpio;
  end
  // Bit count restarts on reset or on leaving gpio mode
  always_ff @(posedge i_rx_link_clk or posedge rx_clr_r) begin
    if (rx_clr_r) begin
      rx_sh_l_r <= '0;
      rx_cnt_l_r <= '0;
    end else begin
      rx_sh_l_r <= {rx_sh_l_r[WORD_W-2:0], i_serial_rx_data}; // R1
      rx_cnt_l_r <= rx_last_l ? '0 : rx_cnt_l_r + CW'(1);
    end
  end
  // Handover clears on reset only, so gpio gives no false word
  always_ff @(posedge i_rx_link_clk or posedge rx_rst_r) begin
    if (rx_rst_r) begin
      rx_word_l_r <= '0;
      rx_tog_l_r <= 1'b0;
    end else if (rx_last_l) begin
      rx_word_l_r <= {rx_sh_l_r[WORD_W-2:0], i_serial_rx_data};
      rx_tog_l_r <= ~rx_tog_l_r;
    end
  end

  // ==========================================================
  // Word handover: toggle crossing, word is stable for a frame
  logic tg_s1_r, tg_s2_r, tg_s3_r;
  wire rx_new = tg_s2_r ^ tg_s3_r;
  wire clr_valid = wr_take & sel_st & i_writedata[SPC_ST_RX_VALID];
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      tg_s3_r <= 1'b0;
      rx_word_r <= '0;
      rx_valid_r <= 1'b0;
    end else begin
      tg_s1_r <= rx_tog_l_r;
      tg_s2_r <= tg_s1_r;
      tg_s3_r <= tg_s2_r;
      if (rx_new) begin
        rx_word_r <= rx_word_l_r;
      end
      rx_valid_r <= rx_new | (rx_valid_r & ~clr_valid);
    end
  end

  // ==========================================================
  // Pin drivers
  wire rxc_oe_nxt = fl_s2_r & (rx_gpio ?
    gp_r[SPC_GP_DIR+SPC_GP_RXC] : rx_dir); // R2 R3 R7
  wire rxc_out_nxt = rx_gpio ? gp_r[SPC_GP_RXC] : int_clk_r; // R2
  wire txc_oe_nxt = fl_s2_r & (tx_gpio ?
    gp_r[SPC_GP_DIR+SPC_GP_TXC] : tx_dir); // R4 R6 R7
  wire txc_out_nxt = tx_gpio ? gp_r[SPC_GP_TXC] : int_clk_r; // R6
  wire txd_oe_nxt = fl_s2_r & (tx_gpio ?
    gp_r[SPC_GP_DIR+SPC_GP_TXD] : 1'b1); // R6 R7
  wire txd_out_nxt = tx_gpio ? gp_r[SPC_GP_TXD] : tx_bit_r; // R6
  wire fs_oe_nxt = fl_s2_r & pc_r[SPC_PC_FS_DIR] & ~tx_gpio;
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_serial_rx_clock_oe <= 1'b0;
      o_serial_rx_clock_out <= 1'b0;
      o_serial_tx_clock_oe <= 1'b0;
      o_serial_tx_clock_out <= 1'b0;
      o_serial_tx_data_oe <= 1'b0;
      o_serial_tx_data_out <= 1'b0;
      o_tx_frame_sync_oe <= 1'b0; // R8
      o_tx_frame_sync_out <= 1'b0;
    end else begin
      o_serial_rx_clock_oe <= rxc_oe_nxt;
      o_serial_rx_clock_out <= rxc_out_nxt;
      o_serial_tx_clock_oe <= txc_oe_nxt;
      o_serial_tx_clock_out <= txc_out_nxt;
      o_serial_tx_data_oe <= txd_oe_nxt;
      o_serial_tx_data_out <= txd_out_nxt;
      o_tx_frame_sync_oe <= fs_oe_nxt;
      o_tx_frame_sync_out <= fs_nxt;
    end
  end

  // ==========================================================
  // Assertions
  a_float_tristate: assert property (@(posedge i_mclk) // R7
    disable iff (!i_reset_n) !fl_s2_r |=> !o_serial_rx_clock_oe
    && !o_serial_tx_clock_oe && !o_serial_tx_data_oe)
    else $error("pins driven while float is low");
  a_rx_gpio_value: assert property (@(posedge i_mclk) // R2
    disable iff (!i_reset_n) rx_gpio |=>
    o_serial_rx_clock_out == $past(gp_r[SPC_GP_RXC]))
    else $error("rx clock pin not following gpio value");
  a_rx_dir_drive: assert property (@(posedge i_mclk) // R3
    disable iff (!i_reset_n) fl_s2_r && !rx_gpio && rx_dir
    |=> o_serial_rx_clock_oe)
    else $error("rx clock pin not driven as output");
  a_tx_clk_input: assert property (@(posedge i_mclk) // R4
    disable iff (!i_reset_n) !tx_gpio && !tx_dir
    |=> !o_serial_tx_clock_oe)
    else $error("tx clock pin driven while input");
  a_tx_shift_load: assert property (@(posedge i_mclk) // R4
    disable iff (!i_reset_n) tx_start |=> tx_cnt_r == CNT_W
    ##0 fs_nxt)
    else $error("transmit word not loaded");
  a_tx_level_read: assert property (@(posedge i_mclk) // R5
    disable iff (!i_reset_n) i_read && waitreq_r && sel_st
    |=> o_readdata[SPC_ST_TX_CLOCK_PIN_LEVEL] == $past(txc_s2_r))
    else $error("status does not show tx clock level");
  a_tx_gpio_value: assert property (@(posedge i_mclk) // R6
    disable iff (!i_reset_n) tx_gpio |=>
    o_serial_tx_data_out == $past(gp_r[SPC_GP_TXD]))
    else $error("tx data pin not following gpio value");
  a_fs_reset_in: assert property (@(posedge i_mclk) // R8
    !i_reset_n |=> !o_tx_frame_sync_oe)
    else $error("frame sync still driven after reset");
  a_rx_word_toggle: assert property (@(posedge i_rx_link_clk) // R1
    disable iff (rx_clr_r) rx_last_l |=>
    rx_tog_l_r != $past(rx_tog_l_r))
    else $error("received word not handed over");
  a_bus_answer: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n) req && waitreq_r |=> !o_waitrequest)
    else $error("bus answer late");
  c_tx_word: cover property (@(posedge i_mclk) tx_start);
  c_rx_word: cover property (@(posedge i_mclk) rx_new);
  c_float_low: cover property (@(posedge i_mclk) !fl_s2_r);
  c_read_rx: cover property (@(posedge i_mclk) take && sel_rx);
endmodule
`default_nettype wire

//--- tb/spc_peer_model.sv
// Serial peripheral model on the far side of the pin control block
`timescale 1ns/1ps
`default_nettype none
module spc_peer_model (
  input wire logic i_rx_go,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_tx_go,
  input wire logic i_tx_hold,
  input wire logic i_tx_pin,
  output logic o_link_clk,
  output logic o_link_oe,
  output logic o_rx_data,
  output logic o_tx_clk,
  output logic o_tx_clk_oe,
  output logic [7:0] o_tx_word,
  output logic o_tx_valid
);
  logic tx_run;
  assign o_tx_clk_oe = tx_run | i_tx_hold;
  initial begin
    o_link_clk = 1'b1;
    o_link_oe = 1'b0;
    o_rx_data = 1'b1;
    o_tx_clk = 1'b0;
    o_tx_word = 8'h00;
    o_tx_valid = 1'b0;
    tx_run = 1'b0;
  end
  // ==========================================================
  // Link clock parks high, so release to the pull-up gives no edge
  always @(posedge i_rx_go) begin
    #3 o_link_oe = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #6 o_link_clk = 1'b0;
      o_rx_data = i_rx_byte[i];
      #6 o_link_clk = 1'b1;
    end
    #6 o_link_oe = 1'b0;
    o_rx_data = ~o_rx_data;
  end
  // Slow external tx clock; capture mid-bit on the falling edge
  always @(posedge i_tx_go) begin
    #37 tx_run = 1'b1;
    for (int i = 0; i < 8; i++) begin
      #1200 o_tx_clk = 1'b1;
      #1200 o_tx_clk = 1'b0;
      o_tx_word = {o_tx_word[6:0], i_tx_pin};
    end
    tx_run = 1'b0;
    o_tx_valid = 1'b1;
    #100 o_tx_valid = 1'b0;
  end
endmodule
`default_nettype wire

//--- tb/spc_pin_ctrl_tb_top.sv
// Testbench for the serial port pin control block
`timescale 1ns/1ps
`default_nettype none
module spc_pin_ctrl_tb_top;
  import spc_pkg::*;
  logic i_mclk, i_reset_n, i_read, i_write, i_float_n, o_waitrequest;
  logic [4:0] i_address;
  logic [31:0] i_writedata, o_readdata;
  logic rxc_oe, rxc_out, txc_oe, txc_out, txd_oe, txd_out, fs_oe, fs_out;
  logic lclk, loe, rxd, tclk, toe, tx_valid, rx_go, tx_go, tx_hold;
  logic [7:0] rx_byte, tx_word, rb, tb;
  logic [2:0] g;
  logic [31:0] exp_q[$], tx_q[$];
  int bad_count, comparisons, cyc, seed;
  // Pull-ups on both clock pins
  wire logic rxc_pin = rxc_oe ? rxc_out : (loe ? lclk : 1'b1);
  wire logic txc_pin = txc_oe ? txc_out : (toe ? tclk : 1'b1);
  wire logic [3:0] oes = {rxc_oe, txc_oe, txd_oe, fs_oe};
  wire logic [5:0] gp = {rxc_oe, rxc_out, txc_oe, txc_out, txd_oe, txd_out};
  spc_pin_ctrl spc_pin_ctrl_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_rx_link_clk(rxc_pin), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_float_n(i_float_n),
    .i_serial_rx_clock_in(rxc_pin), .o_serial_rx_clock_out(rxc_out),
    .o_serial_rx_clock_oe(rxc_oe), .i_serial_tx_clock_in(txc_pin),
    .o_serial_tx_clock_out(txc_out), .o_serial_tx_clock_oe(txc_oe),
    .i_serial_rx_data(rxd), .o_serial_tx_data_out(txd_out),
    .o_serial_tx_data_oe(txd_oe), .o_tx_frame_sync_out(fs_out),
    .o_tx_frame_sync_oe(fs_oe));
  spc_peer_model spc_peer_model_inst (.i_rx_go(rx_go), .i_rx_byte(rx_byte),
    .i_tx_go(tx_go), .i_tx_hold(tx_hold), .i_tx_pin(txd_out),
    .o_link_clk(lclk), .o_link_oe(loe), .o_rx_data(rxd), .o_tx_clk(tclk),
    .o_tx_clk_oe(toe), .o_tx_word(tx_word), .o_tx_valid(tx_valid));
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // For a read, d carries the expected data
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    i_address <= a;
    i_write <= w;
    i_read <= !w;
    i_writedata <= w ? d : 32'h0;
    do @(posedge i_mclk); while (o_waitrequest !== 1'b0);
    i_read <= 1'b0;
    i_write <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  // Watcher and timeout
  always @(posedge i_mclk) begin
    if (i_read === 1'b1 && o_waitrequest === 1'b0)
      check(o_readdata, exp_q.pop_front());
    if (tx_valid === 1'b1) check(32'(tx_word), tx_q.pop_front());
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      summarize();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'hA431;
    {i_reset_n, i_read, i_write, rx_go, tx_go, tx_hold} <= 6'h00;
    i_float_n <= 1'b1;
    i_address <= 5'h00;
    i_writedata <= 32'h0;
    rx_byte <= 8'h00;
    wait_n(8);
    check(32'(oes), 32'h0);
    i_reset_n <= 1'b1;
    wait_n(1);
    bus(0, SPC_OFS_PIN_CTRL, 32'(SPC_PC_RESET));
    bus(0, SPC_OFS_GPIO, 32'(SPC_GP_RESET));
    bus(1, 5'h14, 32'hFFFF_FFFF);
    bus(0, 5'h14, 32'h0);
    bus(1, SPC_OFS_PIN_CTRL, 32'h13);
    wait_n(4);
    check(32'(oes), 32'hF);
    i_float_n <= 1'b0;
    wait_n(6);
    check(32'(oes), 32'h0);
    i_float_n <= 1'b1;
    wait_n(6);
    check(32'(oes), 32'hF);
    i_reset_n <= 1'b0;
    wait_n(3);
    check(32'(fs_oe), 32'h0);
    i_reset_n <= 1'b1;
    wait_n(5);
    check(32'(oes), 32'h2);
    tx_hold <= 1'b1;
    wait_n(6);
    bus(0, SPC_OFS_STATUS, 32'h18);
    tx_hold <= 1'b0;
    wait_n(6);
    bus(0, SPC_OFS_STATUS, 32'h19);
    bus(1, SPC_OFS_PIN_CTRL, 32'hC);
    g = 3'($random(seed));
    bus(1, SPC_OFS_GPIO, {26'h0, 3'b111, g});
    wait_n(4);
    check(32'(gp), 32'({1'b1, g[0], 1'b1, g[1], 1'b1, g[2]}));
    bus(1, SPC_OFS_GPIO, 32'h0);
    wait_n(4);
    check(32'(oes), 32'h0);
    // Frame in gpio mode is dropped; leaving gpio restarts bit count
    rx_go <= 1'b1;
    wait_n(1);
    rx_go <= 1'b0;
    wait_n(4);
    bus(1, SPC_OFS_PIN_CTRL, 32'h0);
    rb = 8'($random(seed));
    rx_byte <= rb;
    rx_go <= 1'b1;
    wait_n(1);
    rx_go <= 1'b0;
    wait_n(8);
    bus(0, SPC_OFS_RX_DATA, 32'(rb));
    bus(0, SPC_OFS_STATUS, {27'h0, ~rb[0], 4'hB});
    bus(1, SPC_OFS_STATUS, 32'h2);
    bus(0, SPC_OFS_STATUS, {27'h0, ~rb[0], 4'h9});
    tb = 8'($random(seed));
    tx_q.push_back(32'(tb));
    bus(1, SPC_OFS_TX_DATA, 32'(tb));
    bus(0, SPC_OFS_STATUS, {27'h0, ~rb[0], 4'hD});
    check(32'(fs_out), 32'h1);
    tx_go <= 1'b1;
    wait_n(1);
    tx_go <= 1'b0;
    for (int k = 0; k < 400 && tx_q.size() != 0; k++) @(posedge i_mclk);
    check(32'(tx_q.size()), 32'h0);
    check(32'(fs_out), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
